// File: hw/reset_state_initializer.sv
// Peripheral reset-state logic: register file reached over APB, forced to its
// reset state while the external reset pin is low.
// Assumes standbyMode comes from logic on clk_sys; the reset pin is asynchronous.
//
// Overview of operation
// - Reset in standby keeps data registers; reset in operation makes them undefined.
// - Serial channel 0 shift register kept in standby, undefined otherwise.
// - Serial channel 0 mode register cleared on any reset.
// - Serial bus control register cleared on any reset.
// - Slave address register kept in standby, undefined otherwise.
// - Converter mode register loaded with 04H, conversion-done bit set.
// - CPU clock, system clock and clock output registers cleared.
// - Serial channel 1 mode cleared; its shift register kept only in standby.
// - Serial transfer done flag cleared on any reset.
// - All interrupt request and enable flags cleared.
// - Global interrupt enable cleared so no vectored interrupt follows.
// - Three external interrupt mode registers cleared.
// - Port output buffers off, output latches and direction registers cleared.
// - Pull-up select cleared, all selectable pull-ups off.
// - Both pulse generator modulo registers held on any reset.
// - Bit sequential buffers kept in standby, undefined otherwise.
// - Data memory 0F8H-0FDH may be left undefined after any reset.
`timescale 1ns/1ns
`default_nettype none
module reset_state_initializer
    import reset_init_pkg::*;
#(
    parameter logic [7:0] UNDEF_FILL = 8'ha5
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              resetPinN,
    input  wire logic              standbyMode,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   periphResetActive,
    output logic [7:0]             portOutLatch,
    output logic [7:0]             portOutEnable,
    output logic                   globalIrqEnable,
    output logic                   ramUndefPulse,
    output logic [7:0]             ramUndefLo,
    output logic [7:0]             ramUndefHi
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic                 rstActive;
        logic                 stbyLatched;
        logic                 ramUndef;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
    } state_type;

    // Power-on image; standby-kept registers start at the fill pattern
    function automatic state_type initState();
        state_type s;
        s = '0;
        for (int i = 0; i < NREG; i++) begin
            s.regs[i] = (regPolicy(i) == POL_CLEAR) ? resetValue(i) : UNDEF_FILL;
        end
        return s;
    endfunction

    localparam state_type ST_INIT = initState();

    state_type st_reg;
    state_type st_next;
    logic      pinSyncN;
    logic      rstReq;
    logic      stbyNow;
    logic [ADDR_W-3:0] wordIdx;
    logic      mapped;
    logic      setupPhase;
    logic      writeDone;

    reset_pin_sync u_pin_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkEn    (clkEn),
        .pinN     (resetPinN),
        .pinSyncN (pinSyncN)
    );

    ////////////////////////////////////////////////////////////////////////////

    assign rstReq     = !pinSyncN;
    // Standby is left by the reset itself, so it is caught on the first cycle
    assign stbyNow    = st_reg.rstActive ? st_reg.stbyLatched : standbyMode;
    assign wordIdx    = paddr[ADDR_W-1:2];
    assign mapped     = (paddr[1:0] == 2'b00) && (int'(wordIdx) <= STATUS_IDX);
    assign setupPhase = psel && !penable;
    assign writeDone  = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr && !rstReq;

    always_comb begin
        st_next           = st_reg;
        st_next.rstActive = rstReq;
        st_next.ramUndef  = 1'b0;
        st_next.pready    = setupPhase;
        st_next.pslverr   = 1'b0;
        if (rstReq && !st_reg.rstActive) begin
            st_next.stbyLatched = standbyMode;
        end
        if (setupPhase) begin
            st_next.pslverr = !mapped || (pwrite && (rstReq || int'(wordIdx) == STATUS_IDX));
            if (!mapped) begin
                st_next.prdata = 32'h0000_0000;
            end else if (int'(wordIdx) == STATUS_IDX) begin
                st_next.prdata = {30'h0000_0000, st_reg.stbyLatched, st_reg.rstActive};
            end else begin
                st_next.prdata = {24'h00_0000, st_reg.regs[wordIdx[4:0]]};
            end
        end
        if (writeDone) begin
            st_next.regs[wordIdx[4:0]] = pwdata[7:0] & regMask(int'(wordIdx[4:0]));
        end
        // Reset dominates any write landing in the same cycle
        if (rstReq) begin
            for (int i = 0; i < NREG; i++) begin
                case (regPolicy(i))
                    POL_CLEAR: st_next.regs[i] = resetValue(i);
                    POL_HOLD:  st_next.regs[i] = st_reg.regs[i];
                    POL_STBY: begin
                        if (!stbyNow) begin
                            st_next.regs[i] = UNDEF_FILL;
                        end else begin
                            st_next.regs[i] = st_reg.regs[i];
                        end
                    end
                    default:   st_next.regs[i] = resetValue(i);
                endcase
            end
        end
        // Tells the RAM owner its scratch window is not to be trusted
        if (!rstReq && st_reg.rstActive) begin
            st_next.ramUndef = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= ST_INIT;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign prdata            = st_reg.prdata;
    assign pready            = st_reg.pready;
    assign pslverr           = st_reg.pslverr;
    assign periphResetActive = st_reg.rstActive;
    assign portOutLatch      = st_reg.regs[PORT_LATCH_IDX];
    assign portOutEnable     = st_reg.regs[PORT_DIR_A_IDX];
    assign globalIrqEnable   = st_reg.regs[GLOBAL_IRQ_IDX][0];
    assign ramUndefPulse     = st_reg.ramUndef;
    // Constant window bounds, held in flops so outputs stay registered
    logic [15:0] ramWin_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ramWin_reg <= {RAM_UNDEF_HI, RAM_UNDEF_LO};
        end else if (clkEn) begin
            ramWin_reg <= {RAM_UNDEF_HI, RAM_UNDEF_LO};
        end
    end
    assign ramUndefLo = ramWin_reg[7:0];
    assign ramUndefHi = ramWin_reg[15:8];

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence sRstCycle;
        rstReq && clkEn;
    endsequence

    sequence sRstStandby;
        sRstCycle ##0 stbyNow;
    endsequence

    sequence sRstRunning;
        sRstCycle ##0 !stbyNow;
    endsequence

    a_standby_capture: assert property ((rstReq && !st_reg.rstActive && clkEn) |=>
        st_reg.stbyLatched == $past(standbyMode)) else $error("standby state not captured");
    a_serial0_kept: assert property (sRstStandby |=> $stable(st_reg.regs[SERIAL0_SHIFT_IDX]))
        else $error("serial0 shift lost in standby reset");
    a_serial0_mode_clear: assert property (sRstCycle |=> st_reg.regs[SERIAL0_MODE_IDX] == 8'h00)
        else $error("serial0 mode not cleared");
    a_bus_ctrl_clear: assert property (sRstCycle |=> st_reg.regs[BUS_CTRL_IDX] == 8'h00)
        else $error("bus control not cleared");
    a_slave_addr_undef: assert property (sRstRunning |=> st_reg.regs[SLAVE_ADDR_IDX] == UNDEF_FILL)
        else $error("slave address not marked undefined");
    a_converter_mode: assert property (sRstCycle |=> st_reg.regs[CONV_MODE_IDX] == 8'h04 &&
        st_reg.regs[CONV_MODE_IDX][CONV_DONE_BIT]) else $error("converter mode not 04");
    a_clock_regs_clear: assert property (sRstCycle |=> (st_reg.regs[CPU_CLOCK_IDX] |
        st_reg.regs[SYS_CLOCK_IDX] | st_reg.regs[CLOCK_OUT_IDX]) == 8'h00)
        else $error("clock control not cleared");
    a_serial1_regs: assert property (sRstStandby |=> st_reg.regs[SERIAL1_MODE_IDX] == 8'h00 &&
        $stable(st_reg.regs[SERIAL1_SHIFT_IDX])) else $error("serial1 reset state wrong");
    a_irq_flags_clear: assert property (sRstCycle |=> (st_reg.regs[DONE_FLAG_IDX] |
        st_reg.regs[IRQ_REQUEST_IDX] | st_reg.regs[IRQ_ENABLE_IDX]) == 8'h00)
        else $error("interrupt flags not cleared");
    // Two reset cycles in a row: no write can land in either of the next two cycles
    a_global_irq_off: assert property (sRstCycle ##1 sRstCycle |=> !globalIrqEnable [*2])
        else $error("global interrupt enable not held off");
    a_ext_mode_clear: assert property (sRstCycle |=> (st_reg.regs[EXT_IRQ0_MODE_IDX] |
        st_reg.regs[EXT_IRQ1_MODE_IDX] | st_reg.regs[EXT_IRQ2_MODE_IDX]) == 8'h00)
        else $error("external interrupt modes not cleared");
    a_port_safe: assert property (sRstCycle |=> portOutEnable == 8'h00 && portOutLatch == 8'h00 &&
        st_reg.regs[PORT_DIR_B_IDX] == 8'h00 && st_reg.regs[PORT_DIR_C_IDX] == 8'h00 &&
        st_reg.regs[PULLUP_SEL_IDX] == 8'h00) else $error("ports not safe after reset");
    a_modulo_held: assert property (sRstCycle |=> $stable(st_reg.regs[MODULO_HIGH_IDX]) &&
        $stable(st_reg.regs[MODULO_LOW_IDX])) else $error("modulo registers disturbed");
    a_bitseq_undef: assert property (sRstRunning |=> st_reg.regs[BIT_SEQ_BUF0_IDX + 3] == UNDEF_FILL)
        else $error("bit buffer not marked undefined");
    a_ram_marker: assert property ((st_reg.rstActive && !rstReq && clkEn) |=> ramUndefPulse ##1
        (!ramUndefPulse || !$past(clkEn))) else $error("memory window marker not a pulse");

endmodule
`default_nettype wire

// File: hw/reset_init_pkg.sv
// Register map, reset values and reset policy of the peripheral reset block.
// Assumes 32-bit APB with one aligned word per register: byte address = 4 * index.
package reset_init_pkg;

    localparam int NREG                 = 28;
    localparam int ADDR_W               = 8;
    localparam int SERIAL0_SHIFT_IDX    = 0;
    localparam int SERIAL0_MODE_IDX     = 1;
    localparam int BUS_CTRL_IDX         = 2;
    localparam int SLAVE_ADDR_IDX       = 3;
    localparam int CONV_MODE_IDX        = 4;
    localparam int CPU_CLOCK_IDX        = 5;
    localparam int SYS_CLOCK_IDX        = 6;
    localparam int CLOCK_OUT_IDX        = 7;
    localparam int SERIAL1_SHIFT_IDX    = 8;
    localparam int SERIAL1_MODE_IDX     = 9;
    localparam int DONE_FLAG_IDX        = 10;
    localparam int IRQ_REQUEST_IDX      = 11;
    localparam int IRQ_ENABLE_IDX       = 12;
    localparam int GLOBAL_IRQ_IDX       = 13;
    localparam int EXT_IRQ0_MODE_IDX    = 14;
    localparam int EXT_IRQ1_MODE_IDX    = 15;
    localparam int EXT_IRQ2_MODE_IDX    = 16;
    localparam int PORT_LATCH_IDX       = 17;
    localparam int PORT_DIR_A_IDX       = 18;
    localparam int PORT_DIR_B_IDX       = 19;
    localparam int PORT_DIR_C_IDX       = 20;
    localparam int PULLUP_SEL_IDX       = 21;
    localparam int MODULO_HIGH_IDX      = 22;
    localparam int MODULO_LOW_IDX       = 23;
    localparam int BIT_SEQ_BUF0_IDX     = 24;
    localparam int STATUS_IDX           = 28;
    localparam int NUM_BIT_SEQ          = 4;
    localparam int CONV_DONE_BIT        = 2;
    localparam logic [7:0] CONV_MODE_RST = 8'h04;
    localparam logic [7:0] CLEAR_VAL     = 8'h00;
    localparam logic [7:0] RAM_UNDEF_LO  = 8'hf8;
    localparam logic [7:0] RAM_UNDEF_HI  = 8'hfd;

    typedef enum logic [2:0] {
        POL_CLEAR = 3'b001,
        POL_HOLD  = 3'b010,
        POL_STBY  = 3'b100
    } policy_type;

    function automatic policy_type regPolicy(input int idx);
        if (idx == SERIAL0_SHIFT_IDX || idx == SLAVE_ADDR_IDX || idx == SERIAL1_SHIFT_IDX ||
            (idx >= BIT_SEQ_BUF0_IDX && idx < BIT_SEQ_BUF0_IDX + NUM_BIT_SEQ))
            return POL_STBY;
        if (idx == MODULO_HIGH_IDX || idx == MODULO_LOW_IDX)
            return POL_HOLD;
        return POL_CLEAR;
    endfunction

    function automatic logic [7:0] resetValue(input int idx);
        return (idx == CONV_MODE_IDX) ? CONV_MODE_RST : CLEAR_VAL;
    endfunction

    // Writable bits; single-bit flags and nibble buffers keep the rest at zero
    function automatic logic [7:0] regMask(input int idx);
        if (idx == DONE_FLAG_IDX || idx == GLOBAL_IRQ_IDX)
            return 8'h01;
        if (idx >= BIT_SEQ_BUF0_IDX && idx < BIT_SEQ_BUF0_IDX + NUM_BIT_SEQ)
            return 8'h0f;
        return 8'hff;
    endfunction

endpackage

// File: hw/reset_pin_sync.sv
// Two-flop synchroniser for the external active-low reset pin.
// Assumes the pin is idle high; frozen along with the rest while clkEn is low.
`timescale 1ns/1ns
`default_nettype none
module reset_pin_sync (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic pinN,
    output logic      pinSyncN
);
    logic stage1;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage1   <= 1'b1;
            pinSyncN <= 1'b1;
        end else if (clkEn) begin
            stage1   <= pinN;
            pinSyncN <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_reset_state_initializer.sv
// Self-checking bench for the peripheral reset-state block.
// Assumes the design package and modules are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module tb_reset_state_initializer import reset_init_pkg::*; ;

    localparam logic [7:0] UNDEF = 8'ha5;

    logic              clk_sys;
    logic              rst;
    logic              clkEn;
    logic              resetPinN;
    logic              standbyMode;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              periphResetActive;
    logic [7:0]        portOutLatch;
    logic [7:0]        portOutEnable;
    logic              globalIrqEnable;
    logic              ramUndefPulse;
    logic [7:0]        ramUndefLo;
    logic [7:0]        ramUndefHi;
    logic [31:0]       rd;
    logic              err;
    int                failures;
    int                samples_checked;

    reset_state_initializer #(.UNDEF_FILL(UNDEF)) reset_state_initializer_inst (
        .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .resetPinN(resetPinN), .standbyMode(standbyMode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .periphResetActive(periphResetActive),
        .portOutLatch(portOutLatch), .portOutEnable(portOutEnable), .globalIrqEnable(globalIrqEnable),
        .ramUndefPulse(ramUndefPulse), .ramUndefLo(ramUndefLo), .ramUndefHi(ramUndefHi)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; bus values read right after an edge are the sampled ones
    task automatic apb(input logic wr, input int addr, input logic [31:0] data);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ADDR_W'(addr);
        pwdata  <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            failures++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Nonzero pattern per register, never equal to the fill value
    function automatic logic [7:0] wv(input int i);
        if (i == DONE_FLAG_IDX || i == GLOBAL_IRQ_IDX)
            return 8'h01;
        return (8'h5a + 8'(i)) & ((i >= BIT_SEQ_BUF0_IDX) ? 8'h0f : 8'hff);
    endfunction

    // Write pattern: narrow registers also get bits above their width, which must read back zero
    function automatic logic [7:0] wd(input int i);
        if (i == DONE_FLAG_IDX || i == GLOBAL_IRQ_IDX || i >= BIT_SEQ_BUF0_IDX)
            return wv(i) | 8'he0;
        return wv(i);
    endfunction

    // Mode 0 after rst, 1 as written, 2 after pin reset in standby, 3 after pin reset running
    function automatic logic [7:0] expd(input int i, input int mode);
        if (mode == 1)
            return wv(i);
        if (i == SERIAL0_SHIFT_IDX || i == SLAVE_ADDR_IDX || i == SERIAL1_SHIFT_IDX || i >= BIT_SEQ_BUF0_IDX)
            return (mode == 2) ? wv(i) : UNDEF;
        if (i == MODULO_HIGH_IDX || i == MODULO_LOW_IDX)
            return (mode == 0) ? UNDEF : wv(i);
        return (i == CONV_MODE_IDX) ? 8'h04 : 8'h00;
    endfunction

    task automatic readAll(input int mode);
        for (int i = 0; i < NREG; i++) begin
            apb(1'b0, 4 * i, 32'h0);
            check(rd, {24'h0, expd(i, mode)});
        end
    endtask

    task automatic portsAre(input logic [7:0] lat, input logic [7:0] dir, input logic ie);
        repeat (2) @(posedge clk_sys);
        check(32'(portOutLatch), 32'(lat));
        check(32'(portOutEnable), 32'(dir));
        check(32'(globalIrqEnable), 32'(ie));
    endtask

    task automatic pinReset(input logic stby);
        int n;
        standbyMode <= stby;
        @(posedge clk_sys);
        resetPinN <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (periphResetActive !== 1'b1 && n < 10);
        check(32'(periphResetActive), 32'h1);
        apb(1'b0, 4 * STATUS_IDX, 32'h0);
        check(rd, {30'h0, stby, 1'b1});
        // Writes while the pin is low must bounce
        apb(1'b1, 4 * PORT_LATCH_IDX, 32'h0000_00ff);
        check(32'(err), 32'h1);
        resetPinN <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (periphResetActive !== 1'b0 && n < 10);
        check(32'(ramUndefPulse), 32'h1);
        @(posedge clk_sys);
        check(32'(ramUndefPulse), 32'h0);
        standbyMode <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        resetPinN = 1'b1;
        standbyMode = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        failures = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check({ramUndefHi, ramUndefLo}, 32'h0000_fdf8);
        readAll(0);
        for (int pass = 0; pass < 2; pass++) begin
            for (int i = 0; i < NREG; i++) begin
                apb(1'b1, 4 * i, {24'habcdef, wd(i)});
                check(32'(err), 32'h0);
            end
            readAll(1);
            portsAre(wv(PORT_LATCH_IDX), wv(PORT_DIR_A_IDX), 1'b1);
            pinReset(pass == 0);
            readAll(pass == 0 ? 2 : 3);
            portsAre(8'h00, 8'h00, 1'b0);
        end
        // Unmapped, read-only and unaligned places refuse
        apb(1'b0, 4 * (STATUS_IDX + 1), 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, 4 * STATUS_IDX, 32'h3);
        check(32'(err), 32'h1);
        apb(1'b1, 4 * GLOBAL_IRQ_IDX + 1, 32'h1);
        check(32'(err), 32'h1);
        portsAre(8'h00, 8'h00, 1'b0);
        finish_test();
    end

    // Whole run is several hundred cycles
    initial begin
        #(20 * 20000);
        failures++;
        finish_test();
    end

endmodule
`default_nettype wire
